// ### hw/spm_entry.sv
`timescale 1ns/100ps
module spm_entry #(
   parameter int unsigned wait1_cyc = spm_entry_pkg::wait1_cycles, // first wait interval in cycles
   parameter int unsigned wait2_cyc = spm_entry_pkg::wait2_cycles, // second wait window in cycles
   parameter logic [19:0] loader_kb = spm_entry_pkg::loader_kb_default // loader size in kilobytes
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_reset_start, // one-cycle pulse: loader began after reset
   input wire logic i_sync_serial_clock_pin, // writer clock pin, async
   input wire logic i_sync_serial_data_pin, // writer data pin, async
   input wire logic i_busy, // programming engine is busy
   input wire logic i_parallel_writer, // access comes from a parallel writer
   input wire logic i_software_lock, // loader software enforces protection
   input wire logic i_ew_req, // erase/write request pulse
   input wire logic [19:0] i_ew_addr, // erase/write target address
   input wire logic i_vec_fetch, // vector fetch request pulse
   input wire logic [19:0] i_vec_addr, // native vector address
   output logic o_prog_mode, // serial programming mode active
   output logic o_user_run, // control passed to user program
   output logic o_serial2_sel, // second serial interface owned by writer
   output logic o_busy_output_pin, // busy toward writer
   output logic o_busy_output_pin_oe, // busy pin driven
   output logic o_ew_grant, // erase/write accepted pulse
   output logic o_ew_deny, // erase/write refused pulse
   output logic o_vec_valid, // redirected vector valid pulse
   output logic [19:0] o_vec_addr // redirected vector address
);
   typedef struct packed {
      logic [1:0] clk_sync; // clock pin synchroniser
      logic [1:0] dat_sync; // data pin synchroniser
      spm_entry_pkg::entry_state_e state; // entry sequencer
      logic [spm_entry_pkg::cnt_w-1:0] cnt; // wait counter
      logic prog_mode;
      logic user_run;
      logic busy;
      logic busy_oe;
      logic ew_grant;
      logic ew_deny;
      logic vec_valid;
      logic [19:0] vec_addr;
   } state_s;

   state_s cur, next_cur;
   logic levels_ok; // data low, clock high
   logic both_high;
   logic [19:0] loader_end; // first address past the loader
   logic in_loader, in_subvec, in_fixed, blocked;

   // decoded pin levels, only from the second synchroniser stage
   // a data pin held low with the clock pin high at a start is read as an attached writer
   assign levels_ok = ~cur.dat_sync[1] & cur.clk_sync[1];
   assign both_high = cur.dat_sync[1] & cur.clk_sync[1];
   assign loader_end = spm_entry_pkg::loader_base + {loader_kb[9:0], 10'h000};

   // region decode for erase/write protection
   always_comb begin
      in_loader = (i_ew_addr >= spm_entry_pkg::loader_base) && (i_ew_addr < loader_end);
      in_subvec = (i_ew_addr >= spm_entry_pkg::subvec_lo) && (i_ew_addr <= spm_entry_pkg::subvec_hi);
      in_fixed = (i_ew_addr >= loader_end) && (i_ew_addr <= spm_entry_pkg::fixed_hi);
      // loader is locked on the serial path even without the software lock; the soft areas need that lock as well
      blocked = (in_loader && !i_parallel_writer)
         || ((in_subvec || in_fixed) && i_software_lock && !i_parallel_writer);
   end

   // next-state logic for sequencer, protection and vector redirect
   always_comb begin
      next_cur = cur;
      next_cur.clk_sync = {cur.clk_sync[0], i_sync_serial_clock_pin};
      next_cur.dat_sync = {cur.dat_sync[0], i_sync_serial_data_pin};
      next_cur.ew_grant = 1'b0;
      next_cur.ew_deny = 1'b0;
      next_cur.vec_valid = 1'b0;
      unique case (cur.state)
         spm_entry_pkg::st_idle: begin
            if (i_reset_start) begin
               next_cur.state = spm_entry_pkg::st_check1;
               next_cur.user_run = 1'b0;
            end
         end
         spm_entry_pkg::st_check1: begin
            if (levels_ok) begin
               next_cur.state = spm_entry_pkg::st_wait1;
               next_cur.cnt = spm_entry_pkg::cnt_w'(wait1_cyc);
            end else begin
               next_cur.state = spm_entry_pkg::st_idle;
               next_cur.user_run = 1'b1;
            end
         end
         spm_entry_pkg::st_wait1: begin
            next_cur.cnt = cur.cnt - 1'b1;
            if (cur.cnt <= spm_entry_pkg::cnt_w'(1)) begin
               next_cur.state = spm_entry_pkg::st_check2;
            end
         end
         spm_entry_pkg::st_check2: begin
            if (levels_ok) begin
               next_cur.state = spm_entry_pkg::st_wait2;
               next_cur.cnt = spm_entry_pkg::cnt_w'(wait2_cyc);
            end else begin
               next_cur.state = spm_entry_pkg::st_idle;
               next_cur.user_run = 1'b1;
            end
         end
         spm_entry_pkg::st_wait2: begin
            next_cur.cnt = cur.cnt - 1'b1;
            if (both_high) begin
               next_cur.state = spm_entry_pkg::st_prog;
               next_cur.prog_mode = 1'b1;
            end else if (cur.cnt <= spm_entry_pkg::cnt_w'(1)) begin
               next_cur.state = spm_entry_pkg::st_idle;
               next_cur.user_run = 1'b1;
            end
         end
         spm_entry_pkg::st_prog: begin
            // stays until the next reset; a reset start rechecks the pins
            if (i_reset_start) begin
               next_cur.state = spm_entry_pkg::st_check1;
               next_cur.prog_mode = 1'b0;
            end
         end
      endcase
      // busy pin only driven while the writer owns the link
      next_cur.busy_oe = next_cur.prog_mode;
      next_cur.busy = next_cur.prog_mode & i_busy;
      if (i_ew_req) begin
         next_cur.ew_grant = !blocked;
         next_cur.ew_deny = blocked;
      end
      // redirect native vectors into the user jump slots, offset kept
      if (i_vec_fetch) begin
         next_cur.vec_valid = 1'b1;
         if (i_vec_addr == spm_entry_pkg::reset_vec) begin
            next_cur.vec_addr = spm_entry_pkg::reset_jump;
         end else if (i_vec_addr >= spm_entry_pkg::irq_vec_lo && i_vec_addr <= spm_entry_pkg::irq_vec_hi) begin
            next_cur.vec_addr = i_vec_addr - spm_entry_pkg::irq_vec_lo + spm_entry_pkg::irq_jump_lo;
         end else begin
            next_cur.vec_addr = i_vec_addr;
         end
      end
   end

   // single state register, synchronous active-low reset
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         // while the writer holds reset the block sits in its reset image
         cur <= '0;
         cur.state <= spm_entry_pkg::st_idle;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_prog_mode = cur.prog_mode;
   assign o_user_run = cur.user_run;
   assign o_serial2_sel = cur.prog_mode;
   assign o_busy_output_pin = cur.busy;
   assign o_busy_output_pin_oe = cur.busy_oe;
   assign o_ew_grant = cur.ew_grant;
   assign o_ew_deny = cur.ew_deny;
   assign o_vec_valid = cur.vec_valid;
   assign o_vec_addr = cur.vec_addr;

   sequence s_check_pass;
      cur.state == spm_entry_pkg::st_check1 && levels_ok;
   endsequence

   a_check_fail_user: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (cur.state == spm_entry_pkg::st_check1 && !levels_ok) |=> o_user_run && !o_prog_mode)
      else $error("failed first check did not hand over to user");
   a_check_pass_wait: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      s_check_pass |=> cur.state == spm_entry_pkg::st_wait1)
      else $error("passing check did not start wait");
   a_prog_needs_high: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      $rose(o_prog_mode) |-> $past(both_high))
      else $error("programming entered without both pins high");
   a_loader_locked: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_ew_req && !i_parallel_writer && i_ew_addr == spm_entry_pkg::loader_base) |=> o_ew_deny && !o_ew_grant)
      else $error("loader region write not blocked");
   a_subvec_locked: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_ew_req && i_software_lock && !i_parallel_writer && i_ew_addr == spm_entry_pkg::subvec_hi) |=> o_ew_deny)
      else $error("subroutine vector write not blocked");
   a_fixed_locked: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_ew_req && i_software_lock && !i_parallel_writer && i_ew_addr == spm_entry_pkg::fixed_hi) |=> o_ew_deny)
      else $error("fixed user write not blocked");
   a_reset_redirect: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_vec_fetch && i_vec_addr == spm_entry_pkg::reset_vec) |=> o_vec_addr == spm_entry_pkg::reset_jump)
      else $error("reset vector not redirected");
   a_irq_redirect: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_vec_fetch && i_vec_addr == spm_entry_pkg::irq_vec_hi) |=> o_vec_addr == spm_entry_pkg::irq_jump_hi)
      else $error("last interrupt vector not redirected");
   a_user_writable: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (i_ew_req && i_ew_addr > spm_entry_pkg::fixed_hi) |=> o_ew_grant)
      else $error("user region write refused");
   a_busy_prog_only: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_busy_output_pin_oe |-> o_prog_mode && o_serial2_sel)
      else $error("busy pin driven outside programming");

   // reset image: nothing is driven toward the writer while reset is held
   a_reset_quiet: assert property (@(posedge i_core_clk)
      !i_resetn |=> !o_prog_mode && !o_user_run && !o_busy_output_pin_oe && !o_ew_grant)
      else $error("outputs not cleared by reset");

   // second level check fails: the pins moved during the first wait
   sequence s_recheck_fail;
      cur.state == spm_entry_pkg::st_check2 && !levels_ok;
   endsequence

   // last cycle of the second window with the pins still not both high
   sequence s_window_lapsed;
      cur.state == spm_entry_pkg::st_wait2 && !both_high && cur.cnt <= spm_entry_pkg::cnt_w'(1);
   endsequence

   // every failed step hands control to the user program, never to programming
   a_recheck_fail: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      s_recheck_fail |=> o_user_run && !o_prog_mode)
      else $error("failed second check did not hand over to user");
   a_window_lapsed: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      s_window_lapsed |=> o_user_run && !o_prog_mode)
      else $error("expired second window did not hand over to user");

   // busy tracks the engine only while programming holds the link
   a_busy_follows: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (cur.state == spm_entry_pkg::st_prog && !i_reset_start && i_busy) |=> o_busy_output_pin)
      else $error("busy pin did not follow engine");

   // a new start while programming drops the link until the pins pass again
   a_restart_drops: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (cur.state == spm_entry_pkg::st_prog && i_reset_start) |=> !o_prog_mode && !o_serial2_sel)
      else $error("restart did not leave programming mode");
endmodule // spm_entry

// ### hw/spm_entry_pkg.sv
package spm_entry_pkg;
   localparam int unsigned clk_period_ns = 100; // core clock period
   localparam int unsigned wait1_ns = 1000; // first wait interval
   localparam int unsigned wait2_ns = 100000; // second wait window
   localparam int unsigned wait1_cycles = (wait1_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int unsigned wait2_cycles = wait2_ns / clk_period_ns;
   localparam int unsigned addr_w = 20; // flash byte address width
   localparam logic [19:0] loader_base = 20'h040c0; // loader region start
   localparam logic [19:0] loader_kb_default = 20'h00001; // n kilobytes
   localparam logic [19:0] subvec_lo = 20'h04080; // subroutine vectors
   localparam logic [19:0] subvec_hi = 20'h040bf;
   localparam logic [19:0] fixed_hi = 20'h057ff; // fixed user region end
   localparam logic [19:0] reset_vec = 20'h04000; // native reset vector
   localparam logic [19:0] reset_jump = 20'h05808; // redirected reset slot
   localparam logic [19:0] irq_vec_lo = 20'h04004; // first interrupt vector
   localparam logic [19:0] irq_vec_hi = 20'h04078; // last interrupt vector
   localparam logic [19:0] irq_jump_lo = 20'h0580c; // first redirected slot
   localparam logic [19:0] irq_jump_hi = 20'h05880; // last redirected slot
   localparam int unsigned cnt_w = 16; // wait counter width
   typedef enum logic [5:0] {
      st_idle = 6'h01, // waiting for reset start
      st_check1 = 6'h02, // first level check
      st_wait1 = 6'h04, // first wait interval
      st_check2 = 6'h08, // second level check
      st_wait2 = 6'h10, // waiting for both pins high
      st_prog = 6'h20 // programming mode active
   } entry_state_e;
endpackage

// ### tb/spm_writer_model.sv
`timescale 1ns/100ps
// behavioural writer: sets pin levels per mode, then runs its timeline from each start pulse
module spm_writer_model (
   input wire logic i_go, // loader start pulse seen by the writer
   input wire logic [2:0] i_mode, // 0 good, 1 clock low, 2 data early, 3 never high, 4 frame
   output logic o_sync_serial_clock_pin,
   output logic o_sync_serial_data_pin
);
   // power-up: both low until a mode is chosen
   initial begin
      o_sync_serial_clock_pin = 1'b0;
      o_sync_serial_data_pin = 1'b0;
   end
   // static levels per mode; the frame toggles the link clock every 400 ns
   always @(i_mode) begin
      o_sync_serial_data_pin = 1'b0;
      o_sync_serial_clock_pin = (i_mode != 3'h1);
      if (i_mode == 3'h4) begin
         repeat (16) begin
            #400 o_sync_serial_clock_pin = ~o_sync_serial_clock_pin;
            o_sync_serial_data_pin = ~o_sync_serial_data_pin;
         end
         o_sync_serial_data_pin = 1'b1; // released lines float high through pull-ups
      end
   end
   // timeline after start in mode 0: hold long enough to pass both checks, then raise the data pin to join the high clock
   always @(posedge i_go) begin
      if (i_mode == 3'h0) begin
         #1200 o_sync_serial_data_pin = 1'b1;
      end else if (i_mode == 3'h2) begin
         #200 o_sync_serial_data_pin = 1'b1; // breaks the hold before the recheck
      end
   end
endmodule // spm_writer_model

// ### tb/serial_program_mode_entry_tb.sv
`timescale 1ns/100ps
module serial_program_mode_entry_tb;
   logic clk = 1'b0, resetn = 1'b0, go = 1'b0, busy = 1'b0, par = 1'b0, lock = 1'b0;
   logic ew_req = 1'b0, vec_fetch = 1'b0, sclk, sdat, prog, urun, s2sel, bpin, boe, grant, deny, vvalid;
   logic [19:0] ew_addr = 20'h0, vec_in = 20'h0, vec_out;
   logic [2:0] mode = 3'h3;
   int num_errors = 0;
   int num_checks = 0;
   always #50 clk = ~clk;
   spm_writer_model writer (.i_go(go), .i_mode(mode), .o_sync_serial_clock_pin(sclk),
      .o_sync_serial_data_pin(sdat));
   spm_entry #(.wait1_cyc(4), .wait2_cyc(20), .loader_kb(20'h00001)) dut (.i_core_clk(clk), .i_resetn(resetn),
      .i_reset_start(go), .i_sync_serial_clock_pin(sclk), .i_sync_serial_data_pin(sdat), .i_busy(busy),
      .i_parallel_writer(par), .i_software_lock(lock), .i_ew_req(ew_req), .i_ew_addr(ew_addr),
      .i_vec_fetch(vec_fetch), .i_vec_addr(vec_in), .o_prog_mode(prog), .o_user_run(urun),
      .o_serial2_sel(s2sel), .o_busy_output_pin(bpin), .o_busy_output_pin_oe(boe), .o_ew_grant(grant),
      .o_ew_deny(deny), .o_vec_valid(vvalid), .o_vec_addr(vec_out));
   // single comparison point
   task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude;
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // entry attempt: pins settle through the synchroniser before the start pulse
   task automatic entry(input logic [2:0] m, input logic exp);
      int n;
      n = 0;
      mode = m;
      repeat (4) @(negedge clk);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      @(negedge clk);
      while (prog !== 1'b1 && urun !== 1'b1 && n < 80) begin
         @(negedge clk);
         n++;
      end
      if (prog !== 1'b1 && urun !== 1'b1) begin
         num_errors++;
         conclude();
      end else begin
         check("prog_mode", {19'h0, prog}, {19'h0, exp});
         check("user_run", {19'h0, urun}, {19'h0, ~exp});
         check("serial2_sel", {19'h0, s2sel}, {19'h0, exp});
         check("busy_oe", {19'h0, boe}, {19'h0, exp});
      end
   endtask
   // erase/write request; result code 1 grant, 2 deny, gathered over the answer window
   task automatic ew(input logic [19:0] a, input logic p, input logic l, input logic [19:0] exp);
      logic g, d;
      ew_addr = a;
      par = p;
      lock = l;
      ew_req = 1'b1;
      @(negedge clk);
      g = grant;
      d = deny;
      ew_req = 1'b0;
      repeat (2) begin
         @(negedge clk);
         g = g | grant;
         d = d | deny;
      end
      check("ew_result", {18'h0, d, g}, exp);
   endtask
   // vector fetch; the redirected address is taken while valid is high
   task automatic vec(input logic [19:0] a, input logic [19:0] exp);
      logic [19:0] got;
      got = 20'hfffff;
      vec_in = a;
      vec_fetch = 1'b1;
      repeat (3) begin
         @(negedge clk);
         vec_fetch = 1'b0;
         if (vvalid === 1'b1) got = vec_out;
      end
      check("vec_addr", got, exp);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      check("prog_reset", {19'h0, prog}, 20'h0);
      check("user_run_reset", {19'h0, urun}, 20'h0);
      entry(3'h1, 1'b0);
      entry(3'h2, 1'b0);
      entry(3'h3, 1'b0);
      entry(3'h0, 1'b1);
      busy = 1'b1;
      repeat (3) @(negedge clk);
      check("busy_pin", {19'h0, bpin}, 20'h1);
      busy = 1'b0;
      repeat (3) @(negedge clk);
      check("busy_pin", {19'h0, bpin}, 20'h0);
      mode = 3'h4;
      repeat (40) @(negedge clk);
      check("prog_in_frame", {19'h0, prog}, 20'h1);
      ew(20'h040c0, 1'b0, 1'b0, 20'h2);
      ew(20'h044bf, 1'b0, 1'b0, 20'h2);
      ew(20'h044bf, 1'b1, 1'b0, 20'h1);
      ew(20'h04080, 1'b0, 1'b1, 20'h2);
      ew(20'h040bf, 1'b0, 1'b1, 20'h2);
      ew(20'h04080, 1'b0, 1'b0, 20'h1);
      ew(20'h044c0, 1'b0, 1'b1, 20'h2);
      ew(20'h057ff, 1'b0, 1'b1, 20'h2);
      ew(20'h057ff, 1'b1, 1'b1, 20'h1);
      ew(20'h05800, 1'b0, 1'b1, 20'h1);
      vec(20'h04000, 20'h05808);
      vec(20'h04004, 20'h0580c);
      vec(20'h04078, 20'h05880);
      vec(20'h06000, 20'h06000);
      // a new start while programming rechecks the pins and fails on a low clock
      entry(3'h1, 1'b0);
      // reset in mid-run clears the hand-over flag, then entry works again
      resetn = 1'b0;
      repeat (3) @(negedge clk);
      check("user_run_midreset", {19'h0, urun}, 20'h0);
      resetn = 1'b1;
      entry(3'h0, 1'b1);
      conclude();
   end
endmodule // serial_program_mode_entry_tb
